// ---- logic/mrc_cfg_regs.sv ----
// remap configuration register bank with write-cache flush control
// assumes byte-wide config access, one cycle per access; read data registered
// Behaviour
// R1: window top supplies bits 35:26, low ones
// R2: window disabled when top below bottom
// R3: delta translates host to memory addresses
// R4: software loads delta as bottom minus ceiling
// R5: memory size field bits 35:27, 128MB
// R6: extended config base gives bits 31:28
// R7: any write locks extended base until reset
// R8: software never writes base 0 or F
// R9: firmware writes extended base during boot
// R10: flush bit drains write cache at priority
// R11: arbiter refuses requests while flush runs
// R12: hardware clears flush bit when done
// R13: scratch register is plain storage
// R14: window bottom supplies bits 35:26, low zeros
// R15: at or above ceiling below 4G not memory; the decoder still counts remap window hits there as memory
// R16: memory address is host minus shifted delta
`timescale 1ns/1ps
`include "mrc_regs.svh"
module mrc_cfg_regs #(
  parameter int HOST_AW = 36,
  parameter int CFG_AW = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire mrc_pkg::mrc_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  input wire mrc_pkg::mrc_host_req_t host_req,
  output mrc_pkg::mrc_decode_t host_dec,
  input wire logic wc_empty,
  output logic wc_flush_hi_pri,
  output logic arb_accept_en
);
  logic [15:0] low_ceil_ff;
  logic [15:0] win_bottom_ff;
  logic [15:0] win_top_ff;
  logic [15:0] delta_ff;
  logic [15:0] mem_size_ff;
  logic [15:0] ext_base_ff;
  logic ext_lock_ff;
  logic [15:0] scratch_ff;
  logic flush_bit_ff;
  mrc_pkg::mrc_flush_state_t fl_state_ff;
  mrc_pkg::mrc_flush_state_t nxt_fl_state;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] word_ofs;
  logic hi_byte;
  logic wr;
  logic flush_req;

  // the decoder and the struct carriers are built for these widths only
  if (($bits(mrc_pkg::mrc_host_req_t) != HOST_AW + 1) || ($bits(mrc_pkg::mrc_cfg_req_t) != 2 * CFG_AW + 2))
  begin : g_width_check
    $error("mrc_cfg_regs: unsupported address width");
  end

  assign word_ofs = {cfg_req.addr[7:1], 1'b0};
  assign hi_byte = cfg_req.addr[0];
  assign wr = cfg_req.wr;

  function automatic logic [15:0] put_byte(input logic [15:0] cur, input logic hi, input logic [7:0] d,
                                           input logic [15:0] mask);
    logic [15:0] v;
    v = hi ? {d, cur[7:0]} : {cur[15:8], d};
    return v & mask;
  endfunction : put_byte

  // low ceiling, window, delta and memory size registers; reserved bits forced to zero
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      low_ceil_ff <= `MRC_RST_LOW_CEIL;
      win_bottom_ff <= `MRC_RST_WIN_BOTTOM;
      win_top_ff <= `MRC_RST_WIN_TOP;
      delta_ff <= `MRC_RST_DELTA;
      mem_size_ff <= `MRC_RST_MEM_SIZE;
    end else if (wr) begin
      if (word_ofs == `MRC_OFS_LOW_CEIL) begin
        low_ceil_ff <= put_byte(low_ceil_ff, hi_byte, cfg_req.wdata, `MRC_MASK_LOW_CEIL);
      end
      if (word_ofs == `MRC_OFS_WIN_BOTTOM) begin
        win_bottom_ff <= put_byte(win_bottom_ff, hi_byte, cfg_req.wdata, `MRC_MASK_WIN);
      end
      if (word_ofs == `MRC_OFS_WIN_TOP) begin
        win_top_ff <= put_byte(win_top_ff, hi_byte, cfg_req.wdata, `MRC_MASK_WIN); // see R1
      end
      if (word_ofs == `MRC_OFS_DELTA) begin
        delta_ff <= put_byte(delta_ff, hi_byte, cfg_req.wdata, `MRC_MASK_WIN); // see R3
      end
      if (word_ofs == `MRC_OFS_MEM_SIZE) begin
        mem_size_ff <= put_byte(mem_size_ff, hi_byte, cfg_req.wdata, `MRC_MASK_MEM_SIZE); // see R5
      end
    end
  end

  // extended config base: first write of either byte locks it, lock holds until reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_base_ff <= `MRC_RST_EXT_BASE;
      ext_lock_ff <= 1'b0;
    end else if (wr && (word_ofs == `MRC_OFS_EXT_BASE) && !ext_lock_ff) begin
      ext_base_ff <= put_byte(ext_base_ff, hi_byte, cfg_req.wdata, `MRC_MASK_EXT_BASE); // see R6
      ext_lock_ff <= 1'b1; // see R7
    end
  end

  // scratch: storage only, feeds nothing but read data
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scratch_ff <= `MRC_RST_SCRATCH;
    end else if (wr && (word_ofs == `MRC_OFS_SCRATCH)) begin
      scratch_ff <= put_byte(scratch_ff, hi_byte, cfg_req.wdata, 16'hffff); // see R13
    end
  end

  // writing zero to the flush bit is ignored; only hardware clears it
  assign flush_req = wr && (cfg_req.addr == `MRC_OFS_FLUSH) && cfg_req.wdata[`MRC_FLUSH_BIT];

  always_comb begin
    nxt_fl_state = fl_state_ff;
    unique case (fl_state_ff)
      mrc_pkg::MRC_FL_IDLE: begin
        if (flush_req) begin
          nxt_fl_state = mrc_pkg::MRC_FL_DRAIN; // see R10
        end
      end
      mrc_pkg::MRC_FL_DRAIN: begin
        // a request landing as the cache empties keeps the drain going, else the bit would stick
        if (wc_empty && !flush_req) begin
          nxt_fl_state = mrc_pkg::MRC_FL_DONE;
        end
      end
      mrc_pkg::MRC_FL_DONE: begin
        if (flush_req) begin
          nxt_fl_state = mrc_pkg::MRC_FL_DRAIN; // see R10
        end else begin
          nxt_fl_state = mrc_pkg::MRC_FL_IDLE;
        end
      end
      default: begin
        nxt_fl_state = mrc_pkg::MRC_FL_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fl_state_ff <= mrc_pkg::MRC_FL_IDLE;
    end else begin
      fl_state_ff <= nxt_fl_state;
    end
  end

  // a new request in the completing cycle wins, so the bit stays set
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flush_bit_ff <= 1'b0;
    end else if (flush_req) begin
      flush_bit_ff <= 1'b1;
    end else if (fl_state_ff == mrc_pkg::MRC_FL_DRAIN && wc_empty) begin
      flush_bit_ff <= 1'b0; // see R12
    end
  end

  assign wc_flush_hi_pri = (fl_state_ff == mrc_pkg::MRC_FL_DRAIN); // see R10
  assign arb_accept_en = (fl_state_ff != mrc_pkg::MRC_FL_DRAIN); // see R11

  always_comb begin
    logic [15:0] w;
    w = 16'h0000;
    unique case (word_ofs)
      `MRC_OFS_LOW_CEIL: w = low_ceil_ff;
      `MRC_OFS_WIN_BOTTOM: w = win_bottom_ff;
      `MRC_OFS_WIN_TOP: w = win_top_ff;
      `MRC_OFS_DELTA: w = delta_ff;
      `MRC_OFS_MEM_SIZE: w = mem_size_ff;
      `MRC_OFS_EXT_BASE: w = ext_base_ff;
      `MRC_OFS_FLUSH: w = {15'h0000, flush_bit_ff};
      `MRC_OFS_SCRATCH: w = scratch_ff;
      default: w = 16'h0000;
    endcase
    nxt_rdata = hi_byte ? w[15:8] : w[7:0];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else if (cfg_req.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign cfg_rdata = rdata_ff;

  mrc_decode u_decode (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .req(host_req),
    .win_bottom(win_bottom_ff[9:0]),
    .win_top(win_top_ff[9:0]),
    .delta(delta_ff[9:0]),
    .low_ceil(low_ceil_ff[15:11]),
    .ext_base(ext_base_ff[15:12]),
    .dec(host_dec)
  );
endmodule : mrc_cfg_regs

// ---- inc/mrc_regs.svh ----
// register offsets, field positions, reset values for the remap configuration bank
// assumes byte-addressed configuration space, one byte lane per address
`ifndef MRC_REGS_SVH
`define MRC_REGS_SVH
`define MRC_OFS_LOW_CEIL 8'hc4
`define MRC_OFS_WIN_BOTTOM 8'hc6
`define MRC_OFS_WIN_TOP 8'hc8
`define MRC_OFS_DELTA 8'hca
`define MRC_OFS_MEM_SIZE 8'hcc
`define MRC_OFS_EXT_BASE 8'hce
`define MRC_OFS_FLUSH 8'hd8
`define MRC_OFS_SCRATCH 8'hde
`define MRC_RST_LOW_CEIL 16'h0800
`define MRC_RST_WIN_BOTTOM 16'h03ff
`define MRC_RST_WIN_TOP 16'h0000
`define MRC_RST_DELTA 16'h0000
`define MRC_RST_MEM_SIZE 16'h0000
`define MRC_RST_EXT_BASE 16'he000
`define MRC_RST_SCRATCH 16'h0000
`define MRC_MASK_WIN 16'h03ff
`define MRC_MASK_MEM_SIZE 16'h01ff
`define MRC_MASK_LOW_CEIL 16'hf800
`define MRC_MASK_EXT_BASE 16'hf000
`define MRC_WIN_LSB 26
`define MRC_SIZE_LSB 27
`define MRC_CEIL_LSB 27
`define MRC_EXT_LSB 28
`define MRC_FLUSH_BIT 0
`endif

// ---- inc/mrc_pkg.sv ----
// types shared by the remap configuration bank and its host decoder
// no constants here: numbers live in mrc_regs.svh
package mrc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mrc_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [35:0] addr;
  } mrc_host_req_t;

  typedef struct packed {
    logic valid;
    logic is_dram;
    logic is_ext_cfg;
    logic remapped;
    logic [35:0] mem_addr;
  } mrc_decode_t;

  typedef enum logic [1:0] {
    MRC_FL_IDLE = 2'b00,
    MRC_FL_DRAIN = 2'b01,
    MRC_FL_DONE = 2'b10
  } mrc_flush_state_t;
endpackage : mrc_pkg

// ---- logic/mrc_decode.sv ----
// host address decoder: remap window, low memory ceiling, extended config window
// assumes register values stable; purely a registered pipeline stage
`timescale 1ns/1ps
`include "mrc_regs.svh"
module mrc_decode (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire mrc_pkg::mrc_host_req_t req,
  input wire logic [9:0] win_bottom,
  input wire logic [9:0] win_top,
  input wire logic [9:0] delta,
  input wire logic [4:0] low_ceil,
  input wire logic [3:0] ext_base,
  output mrc_pkg::mrc_decode_t dec
);
  logic [35:0] lo_bound;
  logic [35:0] hi_bound;
  logic [35:0] ceil_addr;
  logic win_en;
  logic in_win;
  logic below_4g;
  mrc_pkg::mrc_decode_t nxt_dec;
  mrc_pkg::mrc_decode_t dec_ff;

  always_comb begin
    lo_bound = {win_bottom, 26'h0000000}; // see R14
    hi_bound = {win_top, 26'h3ffffff}; // see R1
    ceil_addr = {4'h0, low_ceil, 27'h0000000};
    win_en = !(win_top < win_bottom); // see R2
    in_win = win_en && (req.addr >= lo_bound) && (req.addr <= hi_bound);
    below_4g = (req.addr[35:32] == 4'h0);
    nxt_dec.valid = req.valid;
    nxt_dec.remapped = in_win;
    nxt_dec.is_ext_cfg = below_4g && (req.addr[31:`MRC_EXT_LSB] == ext_base); // see R6
    // at or above the ceiling and below 4 GB is not memory unless it falls in the remap window
    nxt_dec.is_dram = in_win || !(below_4g && (req.addr >= ceil_addr)) || !below_4g; // see R15
    if (in_win) begin
      nxt_dec.mem_addr = req.addr - {delta, 26'h0000000}; // see R3, see R16
    end else begin
      nxt_dec.mem_addr = req.addr;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_ff <= '0;
    end else begin
      dec_ff <= nxt_dec;
    end
  end

  assign dec = dec_ff;
endmodule : mrc_decode

// ---- dv/mrc_cfg_regs_chk.sv ----
// checker: flush handshake and decode outputs of the remap config bank
// assumes it is bound to mrc_cfg_regs and sees only its ports
`timescale 1ns/1ps
module mrc_cfg_regs_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire mrc_pkg::mrc_cfg_req_t cfg_req,
  input wire logic [7:0] cfg_rdata,
  input wire mrc_pkg::mrc_host_req_t host_req,
  input wire mrc_pkg::mrc_decode_t host_dec,
  input wire logic wc_empty,
  input wire logic wc_flush_hi_pri,
  input wire logic arb_accept_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic fl_wr = cfg_req.wr && cfg_req.addr == 8'hd8;
  a_flush_start: assert property (fl_wr && cfg_req.wdata[0] |=> wc_flush_hi_pri) else $error("no flush");
  a_flush_zero: assert property (fl_wr && !cfg_req.wdata[0] && !wc_flush_hi_pri |=> !wc_flush_hi_pri)
    else $error("flush on zero");
  a_arb_refuse: assert property (wc_flush_hi_pri |-> !arb_accept_en) else $error("arbiter open");
  a_arb_idle: assert property (!wc_flush_hi_pri |-> arb_accept_en) else $error("arbiter shut");
  a_flush_hold: assert property (wc_flush_hi_pri && !wc_empty |=> wc_flush_hi_pri) else $error("early end");
  a_flush_done: assert property (wc_flush_hi_pri && wc_empty && !fl_wr
    |=> !wc_flush_hi_pri && arb_accept_en) else $error("flush stuck");
  a_ext_below: assert property (host_dec.is_ext_cfg |-> $past(host_req.addr[35:32]) == 4'h0)
    else $error("ext above 4G");
  a_high_dram: assert property (host_dec.valid && $past(host_req.addr[35:32]) != 4'h0 |-> host_dec.is_dram)
    else $error("high not dram");
  a_rdata_hold: assert property (!$past(cfg_req.rd) |-> $stable(cfg_rdata)) else $error("rdata moved");
  c_flush: cover property (wc_flush_hi_pri ##1 !wc_flush_hi_pri);
  c_remap: cover property (host_dec.remapped);
  c_ext: cover property (host_dec.is_ext_cfg);
endmodule : mrc_cfg_regs_chk

// ---- dv/mrc_cfg_regs_tb_top.sv ----
// self-checking bench for the remap config bank, model kept in an assoc array
// assumes nothing else drives the ports; inputs change at the falling edge
`timescale 1ns/1ps
module mrc_cfg_regs_tb_top;
  logic mclk = 0, sys_rst = 1, wc_empty = 1;
  mrc_pkg::mrc_cfg_req_t cfg_req = '0;
  mrc_pkg::mrc_host_req_t host_req = '0;
  logic [7:0] cfg_rdata;
  mrc_pkg::mrc_decode_t host_dec;
  logic wc_flush_hi_pri, arb_accept_en;
  int num_errors = 0, checks = 0, rv[int], lk;
  int ra[6] = '{'hc4, 'hc6, 'hc8, 'hca, 'hcc, 'hde};
  int hs[6] = '{'h3f, 'h40, 'h41, 'h42, 'h38, 'h02};
  always #2.5 mclk = ~mclk;
  mrc_cfg_regs i_mrc_cfg_regs (.mclk(mclk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .host_req(host_req), .host_dec(host_dec), .wc_empty(wc_empty), .wc_flush_hi_pri(wc_flush_hi_pri),
    .arb_accept_en(arb_accept_en));
  task automatic chk(string n, logic [35:0] e, logic [35:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic idle();
    cfg_req = '0;
    @(negedge mclk);
  endtask : idle
  task automatic do_reset();
    sys_rst = 1;
    cfg_req = '0;
    repeat (4) @(negedge mclk);
    sys_rst = 0;
    rv = '{'hc4: 'h800, 'hc6: 'h3ff, 'hc8: 0, 'hca: 0, 'hcc: 0, 'hce: 'he000, 'hd8: 0, 'hde: 0};
    lk = 0;
  endtask : do_reset
  // reserved bits never store, so the model masks every write
  function automatic int msk(int a);
    case (a)
      'hc4: return 'hf800;
      'hce: return 'hf000;
      'hcc: return 'h1ff;
      'hde: return 'hffff;
      default: return 'h3ff;
    endcase
  endfunction : msk
  task automatic wr(int a, int d);
    int b = a & 'hfe, s = 8 * (a & 1);
    cfg_req = '{1'b1, 1'b0, a[7:0], d[7:0]};
    @(negedge mclk);
    if (b == 'hd8) rv[b] |= (s == 0) & d[0];
    else if (rv.exists(b) && !(b == 'hce && lk)) begin
      rv[b] = (rv[b] & ~('hff << s) | (d & 'hff) << s) & msk(b);
      lk |= b == 'hce;
    end
  endtask : wr
  task automatic rd(int a);
    cfg_req = '{1'b0, 1'b1, a[7:0], 8'h00};
    @(negedge mclk);
    chk($sformatf("rd %h", a), rv.exists(a & 'hfe) ? rv[a & 'hfe] >> 8 * (a & 1) & 'hff : 0, cfg_rdata);
  endtask : rd
  task automatic dec(logic [35:0] a);
    bit rm;
    host_req = '{1'b1, a};
    @(negedge mclk);
    rm = rv['hc6] <= rv['hc8] && a >= 36'(rv['hc6]) << 26 && a <= (36'(rv['hc8]) << 26 | 36'h3ffffff);
    chk("remapped", rm, host_dec.remapped);
    chk("valid", 1, host_dec.valid);
    if (rm) chk("mem_addr", a - (36'(rv['hca]) << 26), host_dec.mem_addr);
    chk("is_dram", rm || a >= 36'h100000000 || a < 36'(rv['hc4]) << 16, host_dec.is_dram);
    chk("is_ext", a < 36'h100000000 && a[31:28] == rv['hce] >> 12, host_dec.is_ext_cfg);
  endtask : dec
  initial begin
    void'($urandom(63484));
    // second pass proves the lock only lasts until reset
    repeat (2) begin
      do_reset();
      for (int a = 'hc4; a < 'he0; a++) rd(a);
      foreach (ra[i]) begin
        wr(ra[i], $urandom);
        wr(ra[i] + 1, $urandom);
        rd(ra[i]);
        rd(ra[i] + 1);
      end
      for (int i = 0; i < 3; i++) wr('hcf - i % 2, 'h10 * (1 + $urandom % 14));
      rd('hcf);
      hs[4] = rv['hce] >> 10;
      wc_empty = 0;
      wr('hd8, 1);
      chk("hi_pri", 1, wc_flush_hi_pri);
      rd('hd8);
      chk("accept_en", 0, arb_accept_en);
      repeat ($urandom % 4) rd('hd8);
      wr('hd8, 1);
      wc_empty = 1;
      idle();
      rv['hd8] = 0;
      chk("accept_en", 1, arb_accept_en);
      chk("hi_pri", 0, wc_flush_hi_pri);
      rd('hd8);
      wr('hd8, 'hfe);
      rd('hd8);
      wr('hc5, 'h10);
      wr('hc6, 'h40);
      wr('hc7, 0);
      wr('hc8, 'h41);
      wr('hc9, 0);
      // delta is bottom minus ceiling in 64 MB units, ceiling at 256 MB
      wr('hca, 'h3c);
      wr('hcb, 0);
      idle();
      for (int i = 0; i < 48; i++) begin
        if (i == 24) wr('hc8, 'h3f);
        dec({hs[i % 6][9:0], 26'($urandom)});
      end
    end
    report_and_stop();
  end
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule : mrc_cfg_regs_tb_top
bind mrc_cfg_regs mrc_cfg_regs_chk i_mrc_cfg_regs_chk (.mclk(mclk), .sys_rst(sys_rst), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .host_req(host_req), .host_dec(host_dec), .wc_empty(wc_empty),
  .wc_flush_hi_pri(wc_flush_hi_pri), .arb_accept_en(arb_accept_en));
